// ---- hdl/cwk_can_top.sv ----
// Purpose: CAN transceiver digital side: data path, bus wake, serial and AHB control
// Assumes: All inputs synchronous to core_clk; single AHB-Lite slave, zero wait
// Notes:   Mode, wake disable and slew come from either the serial port or AHB
//
// Notes on behaviour
// RULE1 - Wake filter accepts a pulse only wider than 0.5 us and below 500 us.
// RULE2 - A rejected pulse clears the pulse counter and gives no wake.
// RULE3 - Each accepted pulse counts; the third one asserts wake.
// RULE4 - Over 500 us between accepted pulses clears the counter without wake.
// RULE5 - Entering active mode ends the wake cycle and clears the wake flag.
// RULE6 - Wake detection can be disabled; then bus activity never wakes.
// RULE7 - Bus driven dominant while txd low, recessive while txd high. Code drives dominant only in active mode, recessive otherwise.
// RULE8 - rxd low while the bus is dominant, high while recessive.
// RULE9 - Serial port samples mosi on each sclk falling edge.
// RULE10 - miso changes after each sclk rising edge; host captures on the fall.
// RULE11 - A serial command for active mode takes effect within 10 us.
// RULE12 - Four slew settings 0 to 3; 3 is fastest.
// RULE13 - Wake stays asserted until active mode is entered.
`timescale 1ns/1ps
module cwk_can_top #(
	parameter int WAKE_MAX_CYC = cwk_pkg::WAKE_MAX_CYC,
	parameter int WAKE_GAP_CYC = cwk_pkg::WAKE_GAP_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Protocol controller side
	input  wire logic        txd,
	output logic             rxd,
	// Bus side
	output logic             can_drive_dom,
	input  wire logic        bus_dom,
	input  wire logic        low_power_wake_receiver,
	output logic [1:0]       slew_sel,
	// Serial control port
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_oe,
	// Status
	output logic             can_active,
	output logic             wake_out,
	output logic             irq
);
	import cwk_pkg::*;

	logic [CTRL_W-1:0] ctrl;
	logic              wake;
	logic [IRQ_W-1:0]  irq_stat;
	logic [IRQ_W-1:0]  irq_mask;
	logic              wr_pend;
	logic [7:0]        wr_addr;
	logic [CTRL_W-1:0] next_ctrl;
	logic              next_wake;
	logic [IRQ_W-1:0]  next_irq_stat;
	logic [IRQ_W-1:0]  next_irq_mask;
	logic              next_wr_pend;
	logic [7:0]        next_wr_addr;
	logic [31:0]       next_hrdata;
	logic              next_can_drive_dom;
	logic              next_rxd;
	logic              next_irq;
	logic              addr_ph;
	logic              data_wr;
	logic              wake_en;
	logic              accept;
	logic              reject;
	logic              wake_hit;
	logic [7:0]        spi_tx;
	logic [7:0]        spi_rx;
	logic              spi_valid;
	logic [31:0]       status_word;

	// Wake counting runs only while idle on the bus and not disabled
	assign wake_en = !ctrl[CTRL_WAKE_DIS] && !ctrl[CTRL_ACTIVE]; // [RULE6] [RULE5]
	assign spi_tx  = {5'h00, bus_dom ? 1'b0 : 1'b1, ctrl[CTRL_ACTIVE], wake};
	assign addr_ph = hsel && hready && htrans[1];
	assign data_wr = wr_pend;

	cwk_wake_filter #(
		.MIN_CYC (WAKE_MIN_CYC),
		.MAX_CYC (WAKE_MAX_CYC),
		.GAP_CYC (WAKE_GAP_CYC),
		.CW      (WAKE_CW)
	) u_filter (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wake_dom (low_power_wake_receiver),
		.enable   (wake_en),
		.accept   (accept),
		.reject   (reject),
		.wake_hit (wake_hit)
	);

	cwk_spi_slave u_spi (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.cs_n     (cs_n),
		.sclk     (sclk),
		.mosi     (mosi),
		.miso     (miso),
		.miso_oe  (miso_oe),
		.tx_byte  (spi_tx),
		.rx_byte  (spi_rx),
		.rx_valid (spi_valid)
	);

	// Control, wake flag and interrupts
	always_comb begin
		next_ctrl     = ctrl;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_wake     = wake;
		next_wr_pend  = addr_ph && hwrite;
		next_wr_addr  = addr_ph ? haddr[7:0] : wr_addr;
		if (data_wr && wr_addr == ADDR_CTRL)
			next_ctrl = hwdata[CTRL_W-1:0];
		// Serial command is taken after AHB so a same-cycle serial frame wins
		if (spi_valid)
			next_ctrl = spi_rx[CTRL_W-1:0]; // [RULE11]
		if (data_wr && wr_addr == ADDR_IRQ_MASK)
			next_irq_mask = hwdata[IRQ_W-1:0];
		if (data_wr && wr_addr == ADDR_IRQ_STAT)
			next_irq_stat = irq_stat & ~hwdata[IRQ_W-1:0];
		// Events set after the clear so a same-cycle event is kept
		if (wake_hit)
			next_irq_stat[IRQ_WAKE] = 1'b1;
		if (reject)
			next_irq_stat[IRQ_REJECT] = 1'b1;
		if (next_ctrl[CTRL_ACTIVE] && !ctrl[CTRL_ACTIVE])
			next_irq_stat[IRQ_ACTIVE] = 1'b1;
		if (next_ctrl[CTRL_ACTIVE])
			next_wake = 1'b0; // [RULE5]
		else if (wake_hit && wake_en)
			next_wake = 1'b1; // [RULE3] [RULE13]
	end

	// Status view built from the next values, so a read sees a same-cycle change
	always_comb begin
		status_word            = 32'h00000000;
		status_word[ST_WAKE]   = next_wake;
		status_word[ST_ACTIVE] = next_ctrl[CTRL_ACTIVE];
		status_word[ST_RXD]    = !bus_dom;
	end

	// Read data, with a write in its data phase forwarded through next_ values
	always_comb begin
		next_hrdata = hrdata;
		if (addr_ph && !hwrite) begin
			case (haddr[7:0])
				ADDR_CTRL:     next_hrdata = {28'h0000000, next_ctrl};
				ADDR_STATUS:   next_hrdata = status_word;
				ADDR_IRQ_STAT: next_hrdata = {29'h00000000, next_irq_stat};
				ADDR_IRQ_MASK: next_hrdata = {29'h00000000, next_irq_mask};
				default:       next_hrdata = 32'h00000000;
			endcase
		end
	end

	// Bus data path
	always_comb begin
		next_can_drive_dom = ctrl[CTRL_ACTIVE] && !txd; // [RULE7]
		next_rxd           = !bus_dom; // [RULE8]
		next_irq           = |(next_irq_stat & next_irq_mask);
	end

	// Control, wake and interrupt state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl       <= CTRL_RESET;
			wake       <= 1'b0;
			irq_stat   <= '0;
			irq_mask   <= '0;
			slew_sel   <= 2'h0;
			can_active <= 1'b0;
			wake_out   <= 1'b0;
			irq        <= 1'b0;
		end else begin
			ctrl       <= next_ctrl;
			wake       <= next_wake;
			irq_stat   <= next_irq_stat;
			irq_mask   <= next_irq_mask;
			slew_sel   <= next_ctrl[CTRL_SLEW_LO +: 2]; // [RULE12]
			can_active <= next_ctrl[CTRL_ACTIVE];
			wake_out   <= next_wake;
			irq        <= next_irq;
		end
	end

	// Register bus: zero wait states and always OKAY
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= next_wr_pend;
			wr_addr   <= next_wr_addr;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Bus data path registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			can_drive_dom <= 1'b0;
			rxd           <= 1'b1;
		end else begin
			can_drive_dom <= next_can_drive_dom;
			rxd           <= next_rxd;
		end
	end

	// Checks on the data path, the wake flag and the register bus
	a_tx_drive_map: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
		##1 can_drive_dom == ($past(ctrl[CTRL_ACTIVE]) && !$past(txd)))
		else $error("bus drive does not follow txd");
	a_rx_report: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE8]
		##1 rxd == !$past(bus_dom))
		else $error("rxd does not follow bus");
	a_wake_three: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
		(wake_hit && wake_en && !spi_valid && !(data_wr && wr_addr == ADDR_CTRL))
		|=> wake && wake_out) else $error("wake not set on third pulse");
	a_wake_sticky: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE13]
		(wake && !next_ctrl[CTRL_ACTIVE]) |=> wake)
		else $error("wake dropped early");
	a_active_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
		$rose(ctrl[CTRL_ACTIVE]) |-> !wake && can_active)
		else $error("active kept wake");
	a_disable_no_wake: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
		(ctrl[CTRL_WAKE_DIS] && !wake) |=> !wake)
		else $error("wake while disabled");
	a_spi_mode: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE11]
		(spi_valid && spi_rx[CTRL_ACTIVE]) |-> ##[1:2] can_active)
		else $error("active mode late after command");
	a_slew_map: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE12]
		##1 slew_sel == ctrl[CTRL_SLEW_LO +: 2])
		else $error("slew select wrong");
	a_filter_accept: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
		reject |-> !accept && !wake_hit)
		else $error("pulse both kept and dropped");
	a_idle_recessive: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
		!ctrl[CTRL_ACTIVE] |=> !can_drive_dom)
		else $error("drive outside active mode");
	a_dominant_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
		(ctrl[CTRL_ACTIVE] && !txd) |=> can_drive_dom)
		else $error("no dominant drive for low txd");
	a_rx_low_dom: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE8]
		bus_dom |=> !rxd)
		else $error("rxd high on dominant bus");
	a_wake_irq_set: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
		wake_hit |=> irq_stat[IRQ_WAKE])
		else $error("wake event not flagged");
	a_reject_irq: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE2]
		reject |=> irq_stat[IRQ_REJECT])
		else $error("reject event not flagged");
	a_reject_no_wake: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE2]
		(reject && !wake) |=> !wake)
		else $error("wake after rejected pulse");
	a_active_irq: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
		$rose(ctrl[CTRL_ACTIVE]) |-> irq_stat[IRQ_ACTIVE])
		else $error("active entry not flagged");
	a_active_wake_low: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
		ctrl[CTRL_ACTIVE] |-> !wake && !wake_out)
		else $error("wake set in active mode");
	a_disabled_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
		!wake_en |=> !accept && !reject && !wake_hit)
		else $error("filter ran while disabled");
	a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
		irq == |(irq_stat & irq_mask))
		else $error("interrupt level wrong");
	a_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		(data_wr && wr_addr == ADDR_IRQ_STAT && hwdata[IRQ_WAKE] && !wake_hit)
		|=> !irq_stat[IRQ_WAKE]) else $error("wake flag not cleared");
	a_ctrl_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(data_wr && wr_addr == ADDR_CTRL && !spi_valid) |=> ctrl == CTRL_W'($past(hwdata)))
		else $error("control write lost");
	a_spi_ctrl: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE11]
		spi_valid |=> ctrl == spi_rx[CTRL_W-1:0])
		else $error("serial command not applied");
	a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		(addr_ph && !hwrite && haddr[7:0] == ADDR_STATUS)
		|=> hrdata[ST_WAKE] == wake && hrdata[ST_ACTIVE] == ctrl[CTRL_ACTIVE])
		else $error("status read wrong");
	a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		(addr_ph && !hwrite && haddr[7:4] != 4'h0) |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_mode_mirror: assert property (@(posedge core_clk) disable iff (!rst_n)
		can_active == ctrl[CTRL_ACTIVE] && wake_out == wake)
		else $error("status pins out of step");
	a_bus_okay: assert property (@(posedge core_clk) disable iff (!rst_n)
		hreadyout && !hresp)
		else $error("bus not ready or error");
endmodule : cwk_can_top

// ---- hdl/cwk_pkg.sv ----
// Purpose: Shared constants for the CAN transceiver wake and data-path logic
// Assumes: core_clk at 125 MHz
// Notes:   Times kept in printed units, cycle counts derived from them
package cwk_pkg;
	localparam int CLK_MHZ        = 125;
	// Wake pulse filter and spacing timeout
	localparam int WAKE_MIN_NS    = 500;
	localparam int WAKE_MAX_US    = 500;
	localparam int WAKE_GAP_US    = 500;
	localparam int WAKE_MIN_CYC   = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_MAX_CYC   = WAKE_MAX_US * CLK_MHZ;
	localparam int WAKE_GAP_CYC   = WAKE_GAP_US * CLK_MHZ;
	localparam int WAKE_PULSES    = 3;
	localparam int WAKE_CW        = 17;
	// Serial command to active mode
	localparam int MODE_DELAY_US  = 10;
	localparam int MODE_DELAY_CYC = MODE_DELAY_US * CLK_MHZ;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	// Control fields (also the low nibble of a serial command byte)
	localparam int CTRL_ACTIVE    = 0;
	localparam int CTRL_WAKE_DIS  = 1;
	localparam int CTRL_SLEW_LO   = 2;
	localparam int CTRL_W         = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// Status fields
	localparam int ST_WAKE        = 0;
	localparam int ST_ACTIVE      = 1;
	localparam int ST_RXD         = 2;
	// Interrupt status fields
	localparam int IRQ_WAKE       = 0;
	localparam int IRQ_ACTIVE     = 1;
	localparam int IRQ_REJECT     = 2;
	localparam int IRQ_W          = 3;
	localparam int SPI_BITS       = 8;
endpackage : cwk_pkg

// ---- hdl/cwk_wake_filter.sv ----
// Purpose: Pulse width filter, pulse counter and spacing timeout for bus wake
// Assumes: wake_dom high while the low power wake receiver sees dominant
// Notes:   Pulse widths judged at the end of each dominant pulse
`timescale 1ns/1ps
module cwk_wake_filter #(
	parameter int MIN_CYC = cwk_pkg::WAKE_MIN_CYC,
	parameter int MAX_CYC = cwk_pkg::WAKE_MAX_CYC,
	parameter int GAP_CYC = cwk_pkg::WAKE_GAP_CYC,
	parameter int CW      = cwk_pkg::WAKE_CW
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Wake receiver and control
	input  wire logic wake_dom,
	input  wire logic enable,
	// Events
	output logic      accept,
	output logic      reject,
	output logic      wake_hit
);
	import cwk_pkg::*;

	logic          dom_q;
	logic [CW-1:0] width;
	logic [CW-1:0] gap;
	logic [1:0]    pulses;
	logic          gap_run;
	logic          next_dom_q;
	logic [CW-1:0] next_width;
	logic [CW-1:0] next_gap;
	logic [1:0]    next_pulses;
	logic          next_gap_run;
	logic          next_accept;
	logic          next_reject;
	logic          next_wake_hit;
	logic          fall;
	logic          good;

	always_comb begin
		fall          = dom_q && !wake_dom;
		good          = (width >= CW'(MIN_CYC)) && (width < CW'(MAX_CYC)); // [RULE1]
		next_dom_q    = wake_dom;
		next_width    = width;
		next_gap      = gap;
		next_pulses   = pulses;
		next_gap_run  = gap_run;
		next_accept   = 1'b0;
		next_reject   = 1'b0;
		next_wake_hit = 1'b0;
		if (!enable) begin
			next_width   = '0;
			next_gap     = '0;
			next_pulses  = '0;
			next_gap_run = 1'b0;
		end else if (fall) begin
			next_width = '0;
			if (good) begin
				next_accept = 1'b1;
				next_gap    = '0;
				if (pulses == 2'(WAKE_PULSES - 1)) begin
					next_wake_hit = 1'b1; // [RULE3]
					next_pulses   = '0;
					next_gap_run  = 1'b0;
				end else begin
					next_pulses  = pulses + 2'h1; // [RULE3]
					next_gap_run = 1'b1;
				end
			end else begin
				next_reject  = 1'b1;
				next_pulses  = '0; // [RULE2]
				next_gap_run = 1'b0;
			end
		end else if (wake_dom) begin
			// Saturate so an endless dominant level still reads as too long
			if (width != CW'(MAX_CYC))
				next_width = width + CW'(1);
			next_gap_run = 1'b0;
		end else if (gap_run) begin
			if (gap == CW'(GAP_CYC)) begin
				next_pulses  = '0; // [RULE4]
				next_gap_run = 1'b0;
			end else begin
				next_gap = gap + CW'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dom_q    <= 1'b0;
			width    <= '0;
			gap      <= '0;
			pulses   <= '0;
			gap_run  <= 1'b0;
			accept   <= 1'b0;
			reject   <= 1'b0;
			wake_hit <= 1'b0;
		end else begin
			dom_q    <= next_dom_q;
			width    <= next_width;
			gap      <= next_gap;
			pulses   <= next_pulses;
			gap_run  <= next_gap_run;
			accept   <= next_accept;
			reject   <= next_reject;
			wake_hit <= next_wake_hit;
		end
	end

	a_reject_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE2]
		reject |-> pulses == 2'h0) else $error("counter kept after reject");
	a_gap_timeout: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
		(enable && !wake_dom && !dom_q && gap_run && gap == CW'(GAP_CYC))
		|=> pulses == 2'h0) else $error("gap timeout did not clear");
endmodule : cwk_wake_filter

// ---- hdl/cwk_spi_slave.sv ----
// Purpose: Serial control port, eight bit frames, MSB first
// Assumes: cs_n, sclk and mosi synchronous to core_clk and slower than it
// Notes:   A frame with other than eight bits is dropped at chip select release
`timescale 1ns/1ps
module cwk_spi_slave (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Serial pins
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       mosi,
	output logic            miso,
	output logic            miso_oe,
	// Byte side
	input  wire logic [7:0] tx_byte,
	output logic [7:0]      rx_byte,
	output logic            rx_valid
);
	import cwk_pkg::*;

	logic       sclk_q;
	logic       cs_q;
	logic [7:0] sh_in;
	logic [7:0] sh_out;
	logic [3:0] bits;
	logic       next_sclk_q;
	logic       next_cs_q;
	logic [7:0] next_sh_in;
	logic [7:0] next_sh_out;
	logic [3:0] next_bits;
	logic       next_miso;
	logic [7:0] next_rx_byte;
	logic       next_rx_valid;

	always_comb begin
		next_sclk_q   = sclk;
		next_cs_q     = cs_n;
		next_sh_in    = sh_in;
		next_sh_out   = sh_out;
		next_bits     = bits;
		next_miso     = miso;
		next_rx_byte  = rx_byte;
		next_rx_valid = 1'b0;
		if (cs_q && !cs_n) begin
			next_sh_out = tx_byte;
			next_miso   = tx_byte[7];
			next_bits   = '0;
		end else if (!cs_n && sclk_q && !sclk) begin
			next_sh_in = {sh_in[6:0], mosi}; // [RULE9]
			// Saturate above eight so long frames are refused, not folded back
			if (bits != 4'hF)
				next_bits = bits + 4'h1;
		end else if (!cs_n && !sclk_q && sclk) begin
			// First rise presents bit 7, so the host's first fall captures the MSB
			next_sh_out = {sh_out[6:0], 1'b0};
			next_miso   = sh_out[7]; // [RULE10]
		end else if (!cs_q && cs_n) begin
			next_rx_valid = (bits == 4'(SPI_BITS));
			next_rx_byte  = sh_in;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q   <= 1'b0;
			cs_q     <= 1'b1;
			sh_in    <= '0;
			sh_out   <= '0;
			bits     <= '0;
			miso     <= 1'b0;
			miso_oe  <= 1'b0;
			rx_byte  <= '0;
			rx_valid <= 1'b0;
		end else begin
			sclk_q   <= next_sclk_q;
			cs_q     <= next_cs_q;
			sh_in    <= next_sh_in;
			sh_out   <= next_sh_out;
			bits     <= next_bits;
			miso     <= next_miso;
			miso_oe  <= !cs_n;
			rx_byte  <= next_rx_byte;
			rx_valid <= next_rx_valid;
		end
	end

	a_mosi_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
		(!cs_n && cs_q == cs_n && sclk_q && !sclk)
		|=> sh_in[0] == $past(mosi)) else $error("mosi not taken on fall");
	a_miso_on_rise: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE10]
		(!cs_n && cs_q == cs_n && !sclk_q && sclk)
		|=> miso == $past(sh_out[7])) else $error("miso not moved on rise");
endmodule : cwk_spi_slave

// ---- verif/cwk_can_partner.sv ----
// Purpose: Far side of the transceiver: CAN bus and low power wake receiver
// Assumes: One other node can pull the bus dominant through ext_dom
// Notes:   Bus is a wired dominant line, no buffering
`timescale 1ns/1ps
module cwk_can_partner (
	// From the transceiver and the other node
	input  wire logic can_drive_dom,
	input  wire logic ext_dom,
	// Bus state seen by both receivers
	output logic      bus_dom,
	output logic      wake_rx
);
	// Any node driving dominant wins over recessive
	assign bus_dom = can_drive_dom | ext_dom;
	// Wake receiver sees the same bus, including our own drive
	assign wake_rx = bus_dom;
endmodule : cwk_can_partner

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the CAN transceiver digital side
// Assumes: Shortened wake counts of 400 cycles
// Notes:   Link cases in a table, wake, serial and interrupt cases by hand
`timescale 1ns/1ps
module tb;
	import cwk_pkg::*;
	typedef struct packed {
		logic [3:0] ctrl;
		logic       txd;
		logic       ext;
		logic       drv;
		logic       rx;
	} cwk_row_t;
	localparam int LIMIT = 40000;
	logic        core_clk, rst_n, hsel, hwrite, txd, ext_dom, cs_n, sclk, mosi;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, slew_sel;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, rxd, can_drive_dom, bus_dom, wake_rx;
	logic        miso, miso_oe, can_active, wake_out, irq;
	logic [7:0]  sb;
	integer      failures, checks_done, cyc, i, n;
	cwk_row_t    rows [5] = '{'{4'h1, 1'b0, 1'b0, 1'b1, 1'b0}, '{4'h5, 1'b1, 1'b0, 1'b0, 1'b1},
		'{4'h9, 1'b0, 1'b0, 1'b1, 1'b0}, '{4'hD, 1'b1, 1'b1, 1'b0, 1'b0},
		'{4'hC, 1'b0, 1'b0, 1'b0, 1'b1}};

	cwk_can_top #(.WAKE_MAX_CYC(400), .WAKE_GAP_CYC(400)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd(txd), .rxd(rxd),
		.can_drive_dom(can_drive_dom), .bus_dom(bus_dom), .low_power_wake_receiver(wake_rx),
		.slew_sel(slew_sel), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .can_active(can_active), .wake_out(wake_out), .irq(irq));
	cwk_can_partner far_end (
		.can_drive_dom(can_drive_dom), .ext_dom(ext_dom), .bus_dom(bus_dom), .wake_rx(wake_rx));

	always #4 core_clk = ~core_clk;

	task finish_test;
		$display("Checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == LIMIT) begin
			failures = failures + 1;
			finish_test();
		end
	end

	task chk_bit(input string nm, input logic e, input logic g);
		checks_done = checks_done + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done = checks_done + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	// Single AHB-Lite transfer; read data taken at the edge ending the data phase
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata;
		// Let outputs launched by the write settle before any caller looks
		@(posedge core_clk);
	endtask : ahb

	// One eight bit frame, MSB first
	task spi(input logic [7:0] b, output logic [7:0] r);
		cs_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk_bit("miso_oe", 1'b1, miso_oe);
		for (int k = 7; k >= 0; k--) begin
			mosi <= b[k]; // Stable well before the fall
			sclk <= 1'b1;
			repeat (3) @(posedge core_clk);
			r[k] = miso; // Host captures at the fall
			sclk <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
		cs_n <= 1'b1;
		mosi <= 1'b0;
		@(posedge core_clk);
	endtask : spi

	task pulse(input int w, input int g);
		ext_dom <= 1'b1;
		repeat (w) @(posedge core_clk);
		ext_dom <= 1'b0;
		repeat (g) @(posedge core_clk);
	endtask : pulse

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		txd = 1'b1;
		ext_dom = 1'b0;
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		failures = 0;
		checks_done = 0;
		cyc = 0;
		repeat (6) @(posedge core_clk);
		chk_bit("reset rxd", 1'b1, rxd);
		chk_bit("reset drive", 1'b0, can_drive_dom);
		chk_bit("reset wake", 1'b0, wake_out);
		chk_bit("reset irq", 1'b0, irq);
		chk_bit("reset miso_oe", 1'b0, miso_oe);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i++) begin
			ahb(1'b1, ADDR_CTRL, {28'h0000000, rows[i].ctrl}, rd);
			txd <= rows[i].txd;
			ext_dom <= rows[i].ext;
			repeat (3) @(posedge core_clk);
			chk_bit("drive", rows[i].drv, can_drive_dom);
			chk_bit("rxd", rows[i].rx, rxd);
			chk_word("slew", {30'h0, rows[i].ctrl[3:2]}, {30'h0, slew_sel});
			ahb(1'b0, ADDR_STATUS, 32'h0, rd);
			chk_word("status", {29'h0, rows[i].rx, rows[i].ctrl[0], 1'b0}, rd);
		end
		txd <= 1'b1;
		chk_bit("hresp", 1'b0, hresp);
		// Widths 63 and 399 pass, 62 rejects and clears the count
		pulse(63, 10);
		pulse(399, 10);
		pulse(62, 10);
		chk_bit("wake short", 1'b0, wake_out);
		ahb(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
		// The first table row entered active mode, so that flag is still set
		chk_word("irq stat reject", 32'h00000006, rd);
		ahb(1'b1, ADDR_IRQ_MASK, 32'h00000004, rd);
		chk_bit("irq masked in", 1'b1, irq);
		ahb(1'b1, ADDR_IRQ_STAT, 32'h00000004, rd);
		chk_bit("irq cleared", 1'b0, irq);
		pulse(100, 10);
		pulse(100, 10);
		pulse(400, 10);
		chk_bit("wake long", 1'b0, wake_out);
		pulse(63, 10);
		pulse(399, 10);
		pulse(100, 10);
		chk_bit("wake third", 1'b1, wake_out);
		pulse(400, 10);
		chk_bit("wake sticky", 1'b1, wake_out);
		// Serial command to active mode; status out reads rxd, active, wake
		spi(8'h01, sb);
		chk_word("miso byte", 32'h00000005, {24'h0, sb});
		n = 0;
		while (can_active !== 1'b1 && n < 1250) begin
			@(posedge core_clk);
			n = n + 1;
		end
		chk_bit("active", 1'b1, can_active);
		@(posedge core_clk);
		chk_bit("wake ends", 1'b0, wake_out);
		ahb(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
		chk_word("irq stat", 32'h00000007, rd);
		ahb(1'b1, ADDR_IRQ_MASK, 32'h00000002, rd);
		chk_bit("irq active", 1'b1, irq);
		ahb(1'b1, ADDR_IRQ_STAT, 32'h00000007, rd);
		ahb(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
		chk_word("irq w1c", 32'h00000000, rd);
		ahb(1'b0, 8'h10, 32'h0, rd);
		chk_word("unmapped", 32'h00000000, rd);
		ahb(1'b1, ADDR_IRQ_MASK, 32'h00000001, rd);
		ahb(1'b1, ADDR_CTRL, 32'h00000002, rd);
		pulse(100, 10);
		pulse(100, 10);
		pulse(100, 10);
		chk_bit("wake disabled", 1'b0, wake_out);
		ahb(1'b1, ADDR_CTRL, 32'h00000000, rd);
		pulse(100, 402);
		pulse(100, 402);
		pulse(100, 10);
		chk_bit("wake gap", 1'b0, wake_out);
		pulse(100, 10);
		pulse(100, 10);
		chk_bit("wake close", 1'b1, wake_out);
		chk_bit("irq wake", 1'b1, irq);
		finish_test();
	end
endmodule : tb
